// ===== rtl/ast_map.vh
// Notes on behaviour
// (R1) host holds reset over ten clocks; the testbench's first reset lasts five clocks
// (R2) encoder inputs: 1 clock, filtered 3 clocks
// (R3) pulser inputs: 1 clock, filtered 3 clocks
// (R4) sensor inputs: 2 clocks, filtered 80 clocks
// (R5) jog and pulser enable: 2, filtered 655360
// (R6) deviation clear width 255 times multiplier
// (R7) width code 111 gives level output
// (R8) ack between one and five clocks
// (R9) read data valid one clock before ack
// (R10) ack released, then wait for strobe low
// (R11) host keeps write data until ack
// (R12) busy within five, pulse within fifteen
// (R13) group lines: drive 8, accept 5
// (R14) command starts deviation clear output
// (R15) command releases deviation clear output
// (R16) command pulses the group start line
`ifndef AST_MAP_VH
`define AST_MAP_VH
`define AST_OFS_ENV1      8'h00
`define AST_OFS_ENV2      8'h04
`define AST_OFS_CMD       8'h08
`define AST_OFS_STAT      8'h0c
`define AST_ENV1_RST      32'h0000_0000
`define AST_ENV2_RST      32'h0000_0000
`define AST_ERCW_LSB      12
`define AST_SENS_FLT_BIT  26
`define AST_JOG_FLT_BIT   27
`define AST_ENC_FLT_BIT   18
`define AST_PLS_FLT_BIT   19
`define AST_STAT_BSY_BIT  16
`define AST_STAT_ERC_BIT  17
`define AST_CMD_GSTA      8'h06
`define AST_CMD_GSTP      8'h07
`define AST_CMD_DEVIATION_CLEAR_ASSERT_CMD    8'h24
`define AST_CMD_ERCREL    8'h25
`define AST_CMD_STOP      8'h49
`define AST_CMD_START     8'h50
`define AST_FAST_CYC      20'd1
`define AST_FAST_FLT_CYC  20'd3
`define AST_SENS_CYC      20'd2
`define AST_SENS_FLT_CYC  20'd80
`define AST_JOG_FLT_CYC   655360
`define AST_GRP_IN_CYC    20'd5
`define AST_GRP_OUT_CYC   4'd8
`define AST_ERC_BASE_CYC  255
`define AST_ERC_LEVEL     3'b111
`define AST_FIRST_PLS_CYC 8'd9
`endif

// ===== rtl/ast_filt.v
`timescale 1ns/10ps
`default_nettype none
module ast_filt #(
	parameter CW = 20
) (
	input  wire          i_clk,
	input  wire          i_rst,
	input  wire          i_d,
	input  wire [CW-1:0] i_len,
	input  wire          i_init,
	output reg           o_q
);
	reg  [CW-1:0] cnt_r;
	wire [CW-1:0] cnt_inc = cnt_r + {{(CW-1){1'b0}}, 1'b1};

	// a new level is taken only after it has stood i_len clocks in a row
	always @(posedge i_clk) begin
		if (i_rst) begin
			cnt_r <= {CW{1'b0}};
			o_q   <= i_init;
		end else if (i_d == o_q) begin
			cnt_r <= {CW{1'b0}};
		end else if (cnt_inc >= i_len) begin
			cnt_r <= {CW{1'b0}};
			o_q   <= i_d;
		end else begin
			cnt_r <= cnt_inc;
		end
	end
endmodule // ast_filt
`default_nettype wire

// ===== rtl/ast_top.v
// The Wishbone slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "ast_map.vh"
module ast_top #(
	parameter [19:0] JOG_FLT_CYC  = `AST_JOG_FLT_CYC,
	parameter [21:0] ERC_BASE_CYC = `AST_ERC_BASE_CYC,
	parameter [7:0]  PULSE_PERIOD = 8'd20
) (
	input  wire        I_MCLK,
	input  wire        I_RST,
	input  wire        I_WB_CYC,
	input  wire        I_WB_STB,
	input  wire        I_WB_WE,
	input  wire [7:0]  I_WB_ADR,
	input  wire [3:0]  I_WB_SEL,
	input  wire [31:0] I_WB_DAT,
	output reg  [31:0] O_WB_DAT,
	output wire        O_WB_ACK,
	input  wire        I_ENCODER_PHASE_ONE,
	input  wire        I_ENCODER_PHASE_TWO,
	input  wire        I_ENCODER_INDEX_INPUT,
	input  wire        I_MANUAL_PULSER_PHASE_ONE,
	input  wire        I_MANUAL_PULSER_PHASE_TWO,
	input  wire        I_SERVO_ALARM_SIGNAL,
	input  wire        I_POSITIONING_DONE_SIGNAL,
	input  wire        I_TRAVEL_LIMIT_SENSOR_POS,
	input  wire        I_TRAVEL_LIMIT_SENSOR_NEG,
	input  wire        I_SLOWDOWN_SENSOR,
	input  wire        I_ORIGIN_SENSOR,
	input  wire        I_MANUAL_JOG_DIRECTION_POS,
	input  wire        I_MANUAL_JOG_DIRECTION_NEG,
	input  wire        I_MANUAL_PULSER_ENABLE_N,
	input  wire        I_GROUP_START_LINE_N,
	output wire        O_GROUP_START_LINE_N,
	output wire        O_GROUP_START_LINE_OE_N,
	input  wire        I_GROUP_STOP_LINE_N,
	output wire        O_GROUP_STOP_LINE_N,
	output wire        O_GROUP_STOP_LINE_OE_N,
	output reg         O_DEVIATION_CLEAR_OUTPUT,
	output wire        O_AXIS_BUSY_OUTPUT_N,
	output reg         O_PULSE_OUT
);
	localparam [1:0] BUS_IDLE = 2'd0;
	localparam [1:0] BUS_PREP = 2'd1;
	localparam [1:0] BUS_ACK  = 2'd2;
	localparam [1:0] BUS_WAIT = 2'd3;
	localparam [31:0] ENV1_RST = `AST_ENV1_RST;
	localparam [31:0] ENV2_RST = `AST_ENV2_RST;

	reg  [1:0]  bus_st_r;
	reg  [1:0]  bus_st_nxt;
	reg  [31:0] env1_r;
	reg  [31:0] env2_r;
	reg  [7:0]  cmd_last_r;
	reg         cmd_go_r;
	reg         start_d_r;
	reg         busy_r;
	reg  [7:0]  pcnt_r;
	reg  [3:0]  gsta_cnt_r;
	reg  [3:0]  gstp_cnt_r;
	reg  [21:0] erc_cnt_r;
	reg         gsta_prev_r;
	reg         gstp_prev_r;
	reg  [31:0] rd_nxt;
	reg  [21:0] erc_len;
	wire [15:0] raw_in;
	wire [15:0] flt_q;
	wire        wr_now;
	wire        cmd_wr;
	wire        enc_f;
	wire        pls_f;
	wire        sens_f;
	wire        jog_f;
	wire        gsta_fall;
	wire        gstp_fall;
	wire [2:0]  erc_code;

	// bus slave: data set one clock ahead of the one-clock ack
	always @* begin
		case (bus_st_r)
			BUS_IDLE: bus_st_nxt = (I_WB_CYC && I_WB_STB) ? BUS_PREP : BUS_IDLE;
			BUS_PREP: bus_st_nxt = BUS_ACK; // [R8]
			BUS_ACK:  bus_st_nxt = BUS_WAIT;
			BUS_WAIT: bus_st_nxt = I_WB_STB ? BUS_WAIT : BUS_IDLE; // [R10]
			default:  bus_st_nxt = BUS_IDLE;
		endcase
	end

	assign O_WB_ACK = (bus_st_r == BUS_ACK); // [R8] [R10]
	// write data sampled only at the ack edge, while the master still holds it
	assign wr_now   = O_WB_ACK && I_WB_CYC && I_WB_STB && I_WB_WE; // [R11]
	assign cmd_wr   = wr_now && (I_WB_ADR == `AST_OFS_CMD) && I_WB_SEL[0];

	always @* begin
		case (I_WB_ADR)
			`AST_OFS_ENV1: rd_nxt = env1_r;
			`AST_OFS_ENV2: rd_nxt = env2_r;
			`AST_OFS_CMD:  rd_nxt = {24'h00_0000, cmd_last_r};
			`AST_OFS_STAT: rd_nxt = {14'h0000, O_DEVIATION_CLEAR_OUTPUT, busy_r, flt_q};
			default:       rd_nxt = 32'h0000_0000;
		endcase
	end

	always @(posedge I_MCLK) begin
		if (I_RST) begin
			bus_st_r <= BUS_IDLE;
			O_WB_DAT <= 32'h0000_0000;
		end else begin
			bus_st_r <= bus_st_nxt;
			if (bus_st_r == BUS_IDLE && bus_st_nxt == BUS_PREP) begin
				O_WB_DAT <= rd_nxt; // [R9]
			end
		end
	end

	genvar b;
	generate
		for (b = 0; b < 4; b = b + 1) begin : g_lane
			always @(posedge I_MCLK) begin
				if (I_RST) begin
					env1_r[8*b+7:8*b] <= ENV1_RST[8*b+7:8*b];
					env2_r[8*b+7:8*b] <= ENV2_RST[8*b+7:8*b];
				end else if (wr_now && I_WB_SEL[b]) begin
					if (I_WB_ADR == `AST_OFS_ENV1) begin
						env1_r[8*b+7:8*b] <= I_WB_DAT[8*b+7:8*b];
					end
					if (I_WB_ADR == `AST_OFS_ENV2) begin
						env2_r[8*b+7:8*b] <= I_WB_DAT[8*b+7:8*b];
					end
				end
			end
		end
	endgenerate

	assign enc_f    = env2_r[`AST_ENC_FLT_BIT];
	assign pls_f    = env2_r[`AST_PLS_FLT_BIT];
	assign sens_f   = env1_r[`AST_SENS_FLT_BIT];
	assign jog_f    = env1_r[`AST_JOG_FLT_BIT];
	assign erc_code = env1_r[`AST_ERCW_LSB+2:`AST_ERCW_LSB];

	// active-low pins are inverted so every filter idles at zero after reset
	assign raw_in = {~I_GROUP_STOP_LINE_N, ~I_GROUP_START_LINE_N, ~I_MANUAL_PULSER_ENABLE_N,
		I_MANUAL_JOG_DIRECTION_NEG, I_MANUAL_JOG_DIRECTION_POS, I_ORIGIN_SENSOR,
		I_SLOWDOWN_SENSOR, I_TRAVEL_LIMIT_SENSOR_NEG, I_TRAVEL_LIMIT_SENSOR_POS,
		I_POSITIONING_DONE_SIGNAL, I_SERVO_ALARM_SIGNAL, I_MANUAL_PULSER_PHASE_TWO,
		I_MANUAL_PULSER_PHASE_ONE, I_ENCODER_INDEX_INPUT, I_ENCODER_PHASE_TWO,
		I_ENCODER_PHASE_ONE};

	generate
		for (b = 0; b < 16; b = b + 1) begin : g_flt
			wire [19:0] len =
				(b < 3)  ? (enc_f ? `AST_FAST_FLT_CYC : `AST_FAST_CYC) :  // [R2]
				(b < 5)  ? (pls_f ? `AST_FAST_FLT_CYC : `AST_FAST_CYC) :  // [R3]
				(b < 11) ? (sens_f ? `AST_SENS_FLT_CYC : `AST_SENS_CYC) : // [R4]
				(b < 14) ? (jog_f ? JOG_FLT_CYC : `AST_SENS_CYC) :        // [R5]
				`AST_GRP_IN_CYC;                                          // [R13]
			ast_filt #(
				.CW (20)
			) u_flt (
				.i_clk  (I_MCLK),
				.i_rst  (I_RST),
				.i_d    (raw_in[b]),
				.i_len  (len),
				.i_init (1'b0),
				.o_q    (flt_q[b])
			);
		end
	endgenerate

	always @(posedge I_MCLK) begin
		if (I_RST) begin
			gsta_prev_r <= 1'b0;
			gstp_prev_r <= 1'b0;
		end else begin
			gsta_prev_r <= flt_q[14];
			gstp_prev_r <= flt_q[15];
		end
	end
	assign gsta_fall = flt_q[14] && !gsta_prev_r;
	assign gstp_fall = flt_q[15] && !gstp_prev_r;

	// command decode: one clock after the ack edge
	always @(posedge I_MCLK) begin
		if (I_RST) begin
			cmd_last_r <= 8'h00;
			cmd_go_r   <= 1'b0;
		end else begin
			cmd_go_r <= cmd_wr && (I_WB_DAT[7:0] == `AST_CMD_START);
			if (cmd_wr) begin
				cmd_last_r <= I_WB_DAT[7:0];
			end
		end
	end

	// group lines: open drain, pulled low for a fixed eight clocks
	always @(posedge I_MCLK) begin
		if (I_RST) begin
			gsta_cnt_r <= 4'd0;
			gstp_cnt_r <= 4'd0;
		end else begin
			if (cmd_wr && I_WB_DAT[7:0] == `AST_CMD_GSTA) begin
				gsta_cnt_r <= `AST_GRP_OUT_CYC; // [R16] [R13]
			end else if (gsta_cnt_r != 4'd0) begin
				gsta_cnt_r <= gsta_cnt_r - 4'd1;
			end
			if (cmd_wr && I_WB_DAT[7:0] == `AST_CMD_GSTP) begin
				gstp_cnt_r <= `AST_GRP_OUT_CYC; // [R13]
			end else if (gstp_cnt_r != 4'd0) begin
				gstp_cnt_r <= gstp_cnt_r - 4'd1;
			end
		end
	end
	assign O_GROUP_START_LINE_N    = 1'b0;
	assign O_GROUP_START_LINE_OE_N = (gsta_cnt_r == 4'd0);
	assign O_GROUP_STOP_LINE_N     = 1'b0;
	assign O_GROUP_STOP_LINE_OE_N  = (gstp_cnt_r == 4'd0);

	// axis run: the profile generator is outside, only start timing lives here
	always @(posedge I_MCLK) begin
		if (I_RST) begin
			start_d_r   <= 1'b0;
			busy_r      <= 1'b0;
			pcnt_r      <= 8'h00;
			O_PULSE_OUT <= 1'b0;
		end else begin
			start_d_r   <= cmd_go_r || gsta_fall;
			O_PULSE_OUT <= 1'b0;
			// a start landing in the same clock as a stop wins while the axis is idle; a busy axis takes the stop
			if (start_d_r && !busy_r) begin
				busy_r <= 1'b1;                 // [R12]
				pcnt_r <= `AST_FIRST_PLS_CYC;   // [R12]
			end else if ((cmd_wr && I_WB_DAT[7:0] == `AST_CMD_STOP) || gstp_fall) begin
				busy_r <= 1'b0;
			end else if (busy_r) begin
				if (pcnt_r == 8'h00) begin
					O_PULSE_OUT <= 1'b1;
					pcnt_r      <= PULSE_PERIOD - 8'd1;
				end else begin
					pcnt_r <= pcnt_r - 8'd1;
				end
			end
		end
	end
	assign O_AXIS_BUSY_OUTPUT_N = ~busy_r;

	// width = base times multiplier; the largest product fits 22 bits
	always @* begin
		case (erc_code)
			3'b000:  erc_len = ERC_BASE_CYC;
			3'b001:  erc_len = ERC_BASE_CYC << 3;
			3'b010:  erc_len = ERC_BASE_CYC << 5;
			3'b011:  erc_len = ERC_BASE_CYC << 7;
			3'b100:  erc_len = ERC_BASE_CYC << 10;
			3'b101:  erc_len = ERC_BASE_CYC << 12;
			3'b110:  erc_len = ERC_BASE_CYC << 13;
			default: erc_len = 22'd0;
		endcase
	end

	always @(posedge I_MCLK) begin
		if (I_RST) begin
			O_DEVIATION_CLEAR_OUTPUT <= 1'b0;
			erc_cnt_r                <= 22'd0;
		end else if (cmd_wr && I_WB_DAT[7:0] == `AST_CMD_ERCREL) begin
			O_DEVIATION_CLEAR_OUTPUT <= 1'b0; // [R15]
			erc_cnt_r                <= 22'd0;
		end else if (cmd_wr && I_WB_DAT[7:0] == `AST_CMD_DEVIATION_CLEAR_ASSERT_CMD) begin
			O_DEVIATION_CLEAR_OUTPUT <= 1'b1; // [R14]
			erc_cnt_r                <= erc_len - 22'd1; // [R6]
		end else if (O_DEVIATION_CLEAR_OUTPUT && erc_code != `AST_ERC_LEVEL) begin
			// level mode never times out, only the release command ends it
			if (erc_cnt_r == 22'd0) begin
				O_DEVIATION_CLEAR_OUTPUT <= 1'b0; // [R6] [R7]
			end else begin
				erc_cnt_r <= erc_cnt_r - 22'd1;
			end
		end
	end
endmodule // ast_top
`default_nettype wire

// ===== verif/ast_chk_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module ast_chk (
	input wire logic        I_MCLK,
	input wire logic        I_RST,
	input wire logic        I_WB_CYC,
	input wire logic        I_WB_STB,
	input wire logic        I_WB_WE,
	input wire logic [7:0]  I_WB_ADR,
	input wire logic [31:0] I_WB_DAT,
	input wire logic        O_WB_ACK,
	input wire logic        O_GROUP_START_LINE_OE_N,
	input wire logic        O_GROUP_STOP_LINE_OE_N,
	input wire logic        O_DEVIATION_CLEAR_OUTPUT,
	input wire logic        O_AXIS_BUSY_OUTPUT_N,
	input wire logic        O_PULSE_OUT
);
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (I_RST);
	// command code as taken on its ack edge, zero otherwise
	logic [7:0] cmd;
	assign cmd = (O_WB_ACK && I_WB_WE && I_WB_ADR == 8'h08) ? I_WB_DAT[7:0] : 8'h00;
	ack_timing_a: assert property ($rose(I_WB_STB) |-> !O_WB_ACK ##1 !O_WB_ACK ##1 O_WB_ACK)
		else $error("ack not two edges after request");
	ack_single_a: assert property (O_WB_ACK |=> !O_WB_ACK)
		else $error("ack held too long");
	ack_in_cycle_a: assert property (O_WB_ACK |-> I_WB_CYC && I_WB_STB)
		else $error("ack outside request");
	sta_width_a: assert property ($fell(O_GROUP_START_LINE_OE_N) |->
		!O_GROUP_START_LINE_OE_N [*8] ##1 O_GROUP_START_LINE_OE_N)
		else $error("group start drive not eight clocks");
	stp_width_a: assert property ($fell(O_GROUP_STOP_LINE_OE_N) |->
		!O_GROUP_STOP_LINE_OE_N [*8] ##1 O_GROUP_STOP_LINE_OE_N)
		else $error("group stop drive not eight clocks");
	sta_cmd_a: assert property (cmd == 8'h06 |=> $fell(O_GROUP_START_LINE_OE_N))
		else $error("group start command not driven");
	erc_on_a: assert property (cmd == 8'h24 |=> O_DEVIATION_CLEAR_OUTPUT)
		else $error("deviation clear not raised");
	erc_off_a: assert property (cmd == 8'h25 |=> !O_DEVIATION_CLEAR_OUTPUT)
		else $error("deviation clear not released");
	busy_start_a: assert property (cmd == 8'h50 |-> ##[1:5] !O_AXIS_BUSY_OUTPUT_N)
		else $error("busy late after start");
	pulse_start_a: assert property (cmd == 8'h50 |-> ##[1:15] O_PULSE_OUT)
		else $error("first pulse late after start");
endmodule // ast_chk
bind ast_top ast_chk i_ast_chk (.I_MCLK, .I_RST, .I_WB_CYC, .I_WB_STB, .I_WB_WE, .I_WB_ADR,
	.I_WB_DAT, .O_WB_ACK, .O_GROUP_START_LINE_OE_N, .O_GROUP_STOP_LINE_OE_N,
	.O_DEVIATION_CLEAR_OUTPUT, .O_AXIS_BUSY_OUTPUT_N, .O_PULSE_OUT);
`default_nettype wire

// ===== verif/ast_far.sv
`timescale 1ns/10ps
`default_nettype none
module ast_far (
	input  wire logic [15:0] i_lvl,
	input  wire logic        i_sta_n,
	input  wire logic        i_sta_oe_n,
	input  wire logic        i_stp_n,
	input  wire logic        i_stp_oe_n,
	output logic      [15:0] o_pin
);
	assign o_pin[12:0] = i_lvl[12:0];
	// pulser enable pin is active low
	assign o_pin[13] = ~i_lvl[13];
	// shared lines pulled up, so a released line reads high, not stale
	assign o_pin[14] = ~(i_lvl[14] | (~i_sta_oe_n & ~i_sta_n));
	assign o_pin[15] = ~(i_lvl[15] | (~i_stp_oe_n & ~i_stp_n));
endmodule // ast_far
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	localparam int DEVIATION_CLEAR_OUTPUT = 4;
	logic        clk  = 1'b0;
	logic        rst  = 1'b1;
	logic        cyc  = 1'b0;
	logic        stb  = 1'b0;
	logic        we   = 1'b0;
	logic [7:0]  adr  = 8'h00;
	logic [3:0]  sel  = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [15:0] lvl  = 16'h0;
	logic [31:0] rdat, got, env;
	logic        ack, sta_n, sta_oe_n, stp_n, stp_oe_n, deviation_clear_output, bsy_n, pls;
	wire  [15:0] pin;
	wire  [3:0]  obs = {pls, bsy_n, deviation_clear_output, sta_oe_n};
	int          num_errors = 0;
	int          check_count = 0;
	int          n;
	// short jog filter and deviation base keep the run brief
	ast_top #(.JOG_FLT_CYC(20'd20), .ERC_BASE_CYC(22'd4)) i_ast_top (.I_MCLK(clk), .I_RST(rst),
		.I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel),
		.I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .I_ENCODER_PHASE_ONE(pin[0]),
		.I_ENCODER_PHASE_TWO(pin[1]), .I_ENCODER_INDEX_INPUT(pin[2]),
		.I_MANUAL_PULSER_PHASE_ONE(pin[3]), .I_MANUAL_PULSER_PHASE_TWO(pin[4]),
		.I_SERVO_ALARM_SIGNAL(pin[5]), .I_POSITIONING_DONE_SIGNAL(pin[6]),
		.I_TRAVEL_LIMIT_SENSOR_POS(pin[7]), .I_TRAVEL_LIMIT_SENSOR_NEG(pin[8]),
		.I_SLOWDOWN_SENSOR(pin[9]), .I_ORIGIN_SENSOR(pin[10]),
		.I_MANUAL_JOG_DIRECTION_POS(pin[11]), .I_MANUAL_JOG_DIRECTION_NEG(pin[12]),
		.I_MANUAL_PULSER_ENABLE_N(pin[13]), .I_GROUP_START_LINE_N(pin[14]),
		.O_GROUP_START_LINE_N(sta_n), .O_GROUP_START_LINE_OE_N(sta_oe_n),
		.I_GROUP_STOP_LINE_N(pin[15]), .O_GROUP_STOP_LINE_N(stp_n),
		.O_GROUP_STOP_LINE_OE_N(stp_oe_n), .O_DEVIATION_CLEAR_OUTPUT(deviation_clear_output),
		.O_AXIS_BUSY_OUTPUT_N(bsy_n), .O_PULSE_OUT(pls));
	ast_far i_ast_far (.i_lvl(lvl), .i_sta_n(sta_n), .i_sta_oe_n(sta_oe_n), .i_stp_n(stp_n),
		.i_stp_oe_n(stp_oe_n), .o_pin(pin));
	initial forever #50 clk = ~clk;
	task automatic tally_and_finish();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	// request held until the ack edge, then dropped for at least one cycle
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int k;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		got = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (k >= 20) begin
			num_errors++;
			tally_and_finish();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hf);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0, 4'hf);
		chk(got, e);
	endtask
	task automatic cmd(input logic [7:0] c);
		wr(8'h08, {24'h0, c});
	endtask
	// edges until the watched output reaches v, bounded by lim
	task automatic wait_obs(input int b, input logic v, input int lim, output int m);
		m = 0;
		do begin
			@(posedge clk);
			m++;
		end while (obs[b] !== v && m < lim);
		if (m >= lim) begin
			num_errors++;
			tally_and_finish();
		end
	endtask
	function automatic int mult(input int c);
		return c == 0 ? 1 : c == 1 ? 8 : c == 2 ? 32 : c == 3 ? 128 : c == 4 ? 1024 :
			c == 5 ? 4096 : 8192;
	endfunction
	int fb[4] = '{0, 3, 5, 11};
	int fe[4] = '{18, 19, 26, 27};
	int fs[4] = '{0, 0, 40, 10};
	int fl[4] = '{6, 6, 90, 30};
	initial begin
		int i;
		void'($urandom(32'h1332801e));
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		rd(8'h00, 32'h0);
		rd(8'h04, 32'h0);
		rd(8'h10, 32'h0);
		env = $urandom;
		wr(8'h00, env);
		n = $urandom;
		bus(1'b1, 8'h00, n, 4'h2);
		rd(8'h00, {env[31:16], n[15:8], env[7:0]});
		wr(8'h00, 32'h0);
		for (i = 0; i < 4; i++) begin
			lvl[fb[i]] <= 1'b1;
			repeat (3) @(posedge clk);
			rd(8'h0c, 32'h1 << fb[i]);
			wr(fe[i] > 20 ? 8'h00 : 8'h04, 32'h1 << fe[i]);
			lvl[fb[i]] <= 1'b0;
			repeat (fl[i]) @(posedge clk);
			lvl[fb[i]] <= 1'b1;
			repeat (fs[i]) @(posedge clk);
			rd(8'h0c, 32'h0);
			repeat (fl[i]) @(posedge clk);
			rd(8'h0c, 32'h1 << fb[i]);
			lvl[fb[i]] <= 1'b0;
			wr(fe[i] > 20 ? 8'h00 : 8'h04, 32'h0);
		end
		repeat (3) begin
			lvl <= 16'($urandom) & 16'h3fff;
			repeat (4) @(posedge clk);
			rd(8'h0c, {16'h0, lvl});
		end
		lvl <= 16'h0;
		for (i = 0; i < 7; i++) begin
			wr(8'h00, i << 12);
			cmd(8'h24);
			wait_obs(1, 1'b0, DEVIATION_CLEAR_OUTPUT * mult(i) + 9, n);
			chk(n - 1 >= (DEVIATION_CLEAR_OUTPUT - 1) * mult(i) && n - 1 <= DEVIATION_CLEAR_OUTPUT * mult(i), 1);
		end
		wr(8'h00, 32'h7000);
		cmd(8'h24);
		repeat (300) @(posedge clk);
		chk(deviation_clear_output, 1);
		cmd(8'h25);
		@(posedge clk);
		chk(deviation_clear_output, 0);
		cmd(8'h50);
		wait_obs(2, 1'b0, 20, n);
		wait_obs(3, 1'b1, 20, i);
		chk(n <= 5, 1);
		chk(n + i <= 15, 1);
		cmd(8'h49);
		wait_obs(2, 1'b1, 20, n);
		cmd(8'h06);
		wait_obs(2, 1'b0, 30, n);
		cmd(8'h07);
		wait_obs(2, 1'b1, 30, n);
		// too short a pulse on the start line must not start the axis
		lvl[14] <= 1'b1;
		repeat (3) @(posedge clk);
		lvl[14] <= 1'b0;
		repeat (20) @(posedge clk);
		chk(bsy_n, 1);
		lvl[14] <= 1'b1;
		repeat (5) @(posedge clk);
		lvl[14] <= 1'b0;
		wait_obs(2, 1'b0, 20, n);
		chk(bsy_n, 0);
		cmd(8'h49);
		rd(8'h08, 32'h49);
		// reset in mid-run, with the clear output held and the axis running
		cmd(8'h24);
		cmd(8'h50);
		wait_obs(2, 1'b0, 20, n);
		rst <= 1'b1;
		repeat (11) @(posedge clk);
		rst <= 1'b0;
		chk({deviation_clear_output, bsy_n}, 2'b01);
		rd(8'h0c, 32'h0);
		rd(8'h00, 32'h0);
		rd(8'h08, 32'h0);
		tally_and_finish();
	end
endmodule // tb_top
`default_nettype wire
